// file: rtl/sbg_break_gen.sv
/*
 Break and idle character generator for the transmit line, with its registers.
 Assumes a single 25 MHz clock, synchronous active-low reset, and a register
 master on the same clock that never asserts read and write together.
*/
`timescale 1ns/1ps
`include "sbg_defs.svh"

module sbg_break_gen
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic tx_out
);
    import sbg_pkg::*;

    sbg_state_type cur;
    sbg_state_type nxt;
    logic lin_master;
    logic [3:0] break_len;
    logic [3:0] idle_len;
    logic bit_end;

    // ----------------------------------------
    // Character lengths
    // ----------------------------------------
    always_comb
    begin
        lin_master = cur.lin_select & ~cur.long_word;
        if (lin_master)
        begin
            break_len = `SBG_BREAK_LIN;
        end
        else if (cur.long_word)
        begin
            break_len = `SBG_BREAK_LONG;
        end
        else
        begin
            break_len = `SBG_BREAK_SHORT;
        end
        idle_len = cur.long_word ? `SBG_IDLE_LONG : `SBG_IDLE_SHORT;
        bit_end = (cur.baud_cnt == 16'h0000) && (cur.bit_cnt == 4'h0);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt = cur;
        // Register writes
        if (reg_write)
        begin
            case (reg_addr)
                `SBG_ADDR_CTRL_ONE: nxt.long_word = reg_wdata[`SBG_BIT_LONG_WORD];
                `SBG_ADDR_CTRL_TWO:
                begin
                    nxt.send_break_request = reg_wdata[`SBG_BIT_SEND_BREAK];
                    nxt.tx_on_bit = reg_wdata[`SBG_BIT_TX_ON];
                end
                `SBG_ADDR_CTRL_THREE: nxt.lin_select = reg_wdata[`SBG_BIT_LIN_SELECT];
                `SBG_ADDR_BAUD_LO: nxt.baud_divider[7:0] = reg_wdata;
                `SBG_ADDR_BAUD_HI: nxt.baud_divider[15:8] = reg_wdata;
                default: ;
            endcase
        end

        // Line sequencer; a new character always starts on a fresh bit boundary
        case (cur.phase)
            SBG_QUIET:
            begin
                nxt.tx = 1'b1;
                if (cur.tx_on_bit && cur.idle_pend)
                begin
                    nxt.phase = SBG_IDLE_CHAR;
                    nxt.idle_pend = 1'b0;
                    nxt.baud_cnt = cur.baud_divider;
                    nxt.bit_cnt = idle_len - 4'h1;
                end
                else if (cur.tx_on_bit && (cur.break_pend || cur.send_break_request))
                begin
                    nxt.phase = SBG_BREAK_CHAR;
                    nxt.break_pend = 1'b0;
                    nxt.baud_cnt = cur.baud_divider;
                    nxt.bit_cnt = break_len - 4'h1;
                    nxt.tx = 1'b0;
                end
            end
            SBG_IDLE_CHAR, SBG_BREAK_CHAR:
            begin
                nxt.tx = (cur.phase == SBG_IDLE_CHAR);
                if (cur.baud_cnt != 16'h0000)
                begin
                    nxt.baud_cnt = cur.baud_cnt - 16'h0001;
                end
                else if (!bit_end)
                begin
                    nxt.baud_cnt = cur.baud_divider;
                    nxt.bit_cnt = cur.bit_cnt - 4'h1;
                end
                else if (cur.phase == SBG_IDLE_CHAR && cur.tx_on_bit
                         && (cur.break_pend || cur.send_break_request))
                begin
                    // Break follows the idle with no gap, so its length stays exact
                    nxt.phase = SBG_BREAK_CHAR;
                    nxt.break_pend = 1'b0;
                    nxt.baud_cnt = cur.baud_divider;
                    nxt.bit_cnt = break_len - 4'h1;
                    nxt.tx = 1'b0;
                end
                else if (cur.phase == SBG_BREAK_CHAR && cur.tx_on_bit && cur.send_break_request)
                begin
                    nxt.baud_cnt = cur.baud_divider;
                    nxt.bit_cnt = break_len - 4'h1;
                    nxt.tx = 1'b0;
                end
                else
                begin
                    nxt.phase = SBG_QUIET;
                    nxt.tx = 1'b1;
                end
            end
            default:
            begin
                nxt.phase = SBG_QUIET;
                nxt.tx = 1'b1;
            end
        endcase

        // Request capture after the sequencer so a new request beats its own clear
        if (reg_write && reg_addr == `SBG_ADDR_CTRL_TWO)
        begin
            if (reg_wdata[`SBG_BIT_SEND_BREAK] && !cur.send_break_request)
            begin
                nxt.break_pend = 1'b1;
            end
            if (!reg_wdata[`SBG_BIT_TX_ON])
            begin
                nxt.tx_was_off = 1'b1;
            end
            else if (cur.tx_was_off)
            begin
                nxt.tx_was_off = 1'b0;
                nxt.idle_pend = 1'b1;
            end
        end

        // Read port, data valid in the following cycle only
        nxt.rdata = 8'h00;
        if (reg_read)
        begin
            case (reg_addr)
                `SBG_ADDR_CTRL_ONE: nxt.rdata[`SBG_BIT_LONG_WORD] = cur.long_word;
                `SBG_ADDR_CTRL_TWO:
                begin
                    nxt.rdata[`SBG_BIT_SEND_BREAK] = cur.send_break_request;
                    nxt.rdata[`SBG_BIT_TX_ON] = cur.tx_on_bit;
                end
                `SBG_ADDR_CTRL_THREE: nxt.rdata[`SBG_BIT_LIN_SELECT] = cur.lin_select;
                `SBG_ADDR_BAUD_LO: nxt.rdata = cur.baud_divider[7:0];
                `SBG_ADDR_BAUD_HI: nxt.rdata = cur.baud_divider[15:8];
                `SBG_ADDR_STATUS: nxt.rdata = {3'h0, lin_master, cur.idle_pend, cur.break_pend,
                                               cur.phase == SBG_IDLE_CHAR, cur.phase == SBG_BREAK_CHAR};
                default: nxt.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.baud_divider <= `SBG_BAUD_RESET;
            cur.phase <= SBG_QUIET;
            cur.tx <= 1'b1;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign reg_rdata = cur.rdata;
    assign tx_out = cur.tx;

endmodule

// file: rtl/sbg_defs.svh
/*
 Offsets, field positions, reset values and bit counts of the break generator.
 Assumes inclusion by its bare name from the design module only.
*/
// How it works
// - Set-then-clear of break bit sends one break, 10, 11 or 13 bit times.
// - Breaks repeat back to back while the break bit stays set.
// - LIN master mode when LIN select set and long word cleared.
// - LIN master mode break lasts 13 bit times.
// - Clearing then setting transmit enable queues one idle character.
// - Queued idle puts 10 or 11 idle bit times before the break.
// - Idle then break gives a break of exactly nominal length.
`ifndef SBG_DEFS_SVH
`define SBG_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBG_ADDR_CTRL_ONE 3'h0
`define SBG_ADDR_CTRL_TWO 3'h1
`define SBG_ADDR_CTRL_THREE 3'h2
`define SBG_ADDR_BAUD_LO 3'h3
`define SBG_ADDR_BAUD_HI 3'h4
`define SBG_ADDR_STATUS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SBG_BIT_LONG_WORD 4
`define SBG_BIT_TX_ON 3
`define SBG_BIT_SEND_BREAK 0
`define SBG_BIT_LIN_SELECT 6

// ----------------------------------------
// Reset values and bit counts
// ----------------------------------------
`define SBG_BAUD_RESET 16'h0515
`define SBG_BREAK_SHORT 4'hA
`define SBG_BREAK_LONG 4'hB
`define SBG_BREAK_LIN 4'hD
`define SBG_IDLE_SHORT 4'hA
`define SBG_IDLE_LONG 4'hB

`endif

// file: rtl/sbg_pkg.sv
/*
 Types of the break generator: line phase and the module state record.
 Assumes sbg_defs.svh for nothing but shares its naming.
*/
package sbg_pkg;

    // ----------------------------------------
    // Line phases
    // ----------------------------------------
    typedef enum logic [1:0] {
        SBG_QUIET,
        SBG_IDLE_CHAR,
        SBG_BREAK_CHAR
    } sbg_phase_type;

    // ----------------------------------------
    // State record
    // ----------------------------------------
    typedef struct packed {
        logic long_word;
        logic lin_select;
        logic send_break_request;
        logic tx_on_bit;
        logic tx_was_off;
        logic [15:0] baud_divider;
        logic break_pend;
        logic idle_pend;
        sbg_phase_type phase;
        logic [15:0] baud_cnt;
        logic [3:0] bit_cnt;
        logic tx;
        logic [7:0] rdata;
    } sbg_state_type;

endpackage

// file: verif/sbg_break_gen_properties.sv
/*
 Port checker for the break generator.
 Assumes binding to sbg_break_gen on its single clock.
*/
`timescale 1ns/1ps
module sbg_checker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr(a); reg_write && reg_addr == a; endsequence
    sequence s_rd(a); reg_read && reg_addr == a; endsequence
    property p_rd_zero; !reg_read |=> reg_rdata == 8'h00; endproperty
    property p_rst_line; $rose(rst_n) |-> tx_out && reg_rdata == 8'h00; endproperty
    property p_unmapped; reg_read && reg_addr > 3'h5 |=> reg_rdata == 8'h00; endproperty
    property p_status_rsv; s_rd(3'h5) |=> reg_rdata[7:5] == 3'h0; endproperty
    property p_word; s_wr(3'h0) ##1 s_rd(3'h0) |=> reg_rdata[4] == $past(reg_wdata[4], 2); endproperty
    property p_lin_sel; s_wr(3'h2) ##1 s_rd(3'h2) |=> reg_rdata[6] == $past(reg_wdata[6], 2); endproperty
    property p_baud; s_wr(3'h3) ##1 s_rd(3'h3) |=> reg_rdata == $past(reg_wdata, 2); endproperty
    // A break is ten bit times at least; the check asks for eight cycles low after the fall
    property p_break_min; $fell(tx_out) |-> !tx_out [*8]; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
    a_rst_line: assert property (p_rst_line) else $error("line or data wrong after reset");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_status_rsv: assert property (p_status_rsv) else $error("status spare bits set");
    a_word: assert property (p_word) else $error("word length readback");
    a_lin_sel: assert property (p_lin_sel) else $error("LIN select readback");
    a_baud: assert property (p_baud) else $error("divider readback");
    a_break_min: assert property (p_break_min) else $error("break too short");
endmodule

bind sbg_break_gen sbg_checker sbg_checker_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_out(tx_out));

// file: verif/sbg_line_node.sv
/*
 Far node on the serial line: measures each low run.
 Assumes the line is sampled on the transmitter clock.
*/
`timescale 1ns/1ps
module sbg_line_node
(
    input wire logic clk,
    input wire logic line,
    output int low_len = 0,
    output int n_breaks = 0
);
    int run = 0;
    logic prev = 1'b1;
    // Back to back breaks merge into one low run
    always @(posedge clk)
    begin
        prev <= line;
        run <= (line === prev) ? run + 1 : 1;
        if (prev === 1'b0 && line === 1'b1)
        begin
            low_len <= run;
            n_breaks <= n_breaks + 1;
        end
    end
endmodule

// file: verif/test_sbg_break_gen.sv
/*
 Self-checking bench of the break generator.
 Assumes the divider set to 1, so one bit time is two cycles.
*/
`timescale 1ns/1ps
module test_sbg_break_gen;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic tx_out;
    int low_len;
    int n_breaks;
    int error_cnt = 0;
    int n_compared = 0;
    sbg_break_gen sbg_break_gen_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_out(tx_out));
    sbg_line_node sbg_line_node_i (.clk(clk), .line(tx_out), .low_len(low_len), .n_breaks(n_breaks));
    initial forever #20 clk = ~clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
    endtask
    task automatic quiet();
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    // Leaves one spare cycle so strobes never toggle twice in a step
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge clk);
    endtask
    task automatic t_regs();
        rd(3'h3, 8'h15);
        rd(3'h4, 8'h05);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        wr(3'h3, 8'h01);
        rd(3'h3, 8'h01);
        wr(3'h4, 8'h00);
        quiet();
        $display("regs done");
    endtask
    task automatic t_mode(input logic m, input logic lin, input int bits);
        int k;
        int nb;
        nb = n_breaks;
        wr(3'h0, {3'h0, m, 4'h0});
        rd(3'h0, {3'h0, m, 4'h0});
        wr(3'h2, {1'b0, lin, 6'h00});
        rd(3'h2, {1'b0, lin, 6'h00});
        wr(3'h1, 8'h00);
        wr(3'h1, 8'h08);
        wr(3'h1, 8'h09);
        wr(3'h1, 8'h08);
        rd(3'h5, {3'h0, lin & ~m, 4'h6});
        k = 5;
        while (k < 60 && tx_out !== 1'b0)
        begin
            @(posedge clk);
            #1 k++;
        end
        check(k, 2 * (m ? 11 : 10) + 2);
        for (k = 0; k < 80 && n_breaks == nb; k++) @(posedge clk);
        #1 check(low_len, 2 * bits);
        repeat (40) @(posedge clk);
        check(n_breaks, nb + 1);
        rd(3'h5, {3'h0, lin & ~m, 4'h0});
        $display("mode %0b%0b done", m, lin);
    endtask
    task automatic t_repeat();
        int k;
        int nb;
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        nb = n_breaks;
        wr(3'h1, 8'h09);
        quiet();
        rd(3'h5, 8'h01);
        repeat (26) @(posedge clk);
        wr(3'h1, 8'h08);
        quiet();
        for (k = 0; k < 80 && n_breaks == nb; k++) @(posedge clk);
        #1 check(low_len, 40);
        $display("repeat done");
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        $display("BAD at %0t: timeout", $time);
        conclude();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_mode(1'b0, 1'b0, 10);
        t_mode(1'b1, 1'b0, 11);
        t_mode(1'b0, 1'b1, 13);
        t_mode(1'b1, 1'b1, 11);
        t_repeat();
        conclude();
    end
endmodule
